// File: design/adc_ctrl_pkg.sv
// constants for the converter input control block
package adc_ctrl_pkg;
  // register offsets are not multiples of four: kept as indices, byte address is index*4
  localparam logic [7:0] input_control_index = 8'hda;
  localparam logic [7:0] data_high_index = 8'hdd;
  localparam logic [7:0] input_control_reset = 8'h00;
  localparam logic [7:0] data_high_reset = 8'h00;
  localparam int addr_width = 10;
  // input control fields
  localparam int connect_bit = 7;
  localparam int internal_reference_select_bit = 6;
  localparam int trig_hi = 5;
  localparam int trig_lo = 4;
  localparam int differential_enable_bit = 3;
  localparam int chan_hi = 2;
  localparam int chan_lo = 0;
  // trigger source codes
  localparam logic [1:0] trig_software = 2'h0;
  localparam logic [1:0] trig_timer0 = 2'h1;
  localparam logic [1:0] trig_timer1 = 2'h2;
  localparam logic [1:0] trig_timer2 = 2'h3;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;
  typedef enum logic [1:0] {
    bus_idle = 2'b01,
    bus_data = 2'b10
  } bus_state_t;
endpackage

// File: design/reg_access_if.sv
// register access strobes between bus slave and register file
`timescale 1ns/100ps
`default_nettype none
interface reg_access_if;
  logic wr_en;
  logic [7:0] wr_index;
  logic [7:0] wr_data;
  logic [7:0] rd_index;
  logic [7:0] rd_data;
  modport slave (output wr_en, output wr_index, output wr_data, output rd_index,
    input rd_data);
  modport regs (input wr_en, input wr_index, input wr_data, input rd_index,
    output rd_data);
endinterface
`default_nettype wire

// File: design/ahb_reg_slave.sv
// ahb-lite slave front end
`timescale 1ns/100ps
`default_nettype none
module ahb_reg_slave
  import adc_ctrl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  reg_access_if.slave acc
);
  bus_state_t state;
  bus_state_t next_state;
  logic pend_write;
  logic next_pend_write;
  logic [7:0] pend_index;
  logic [7:0] next_pend_index;
  logic [31:0] next_hrdata;
  logic take;

  assign take = hsel && hready && (htrans == htrans_nonseq) && (hsize == hsize_word);

  always_comb begin
    next_state = take ? bus_data : bus_idle;
    next_pend_write = take && hwrite;
    next_pend_index = take ? haddr[addr_width-1:2] : pend_index;
    next_hrdata = hrdata;
    if (take && !hwrite) begin
      next_hrdata = {24'h000000, acc.rd_data};
    end
  end

  assign acc.rd_index = haddr[addr_width-1:2];
  assign acc.wr_en = (state == bus_data) && pend_write;
  assign acc.wr_index = pend_index;
  assign acc.wr_data = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= bus_idle;
      pend_write <= 1'b0;
      pend_index <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      state <= next_state;
      pend_write <= next_pend_write;
      pend_index <= next_pend_index;
      hrdata <= next_hrdata;
    end
  end
endmodule
`default_nettype wire

// File: design/adc_input_control_regs.sv
// converter input control and data high registers with ahb-lite access
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// (R1) reset clears the input control register to zero.
// (R2) with connect low no analog input reaches the converter.
// (R3) with connect high the channel selected by the code is routed to the converter.
// (R4) software clears connect before changing the channel code.
// (R5) the reference bit picks the internal reference when one, the supply when zero.
// (R6) the differential bit picks differential mode and changes channel decoding.
// (R7) a selected timer starts a conversion on each of its overflows.
// (R8) trigger code 00 is software, 01 timer 0, 10 timer 1, 11 timer 2.
module adc_input_control_regs
  import adc_ctrl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] result_high,
  input wire logic result_load,
  input wire logic go_bit,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  output logic [7:0] positive_input_enable,
  output logic [7:0] negative_input_enable,
  output logic half_supply_negative,
  output logic internal_reference_select,
  output logic differential_enable,
  output logic conversion_start
);
  ////////////////////////////////////////////////////////////////////////////////
  reg_access_if acc ();
  logic [7:0] input_control;
  logic [7:0] next_input_control;
  logic [7:0] data_high;
  logic [7:0] next_data_high;
  logic [7:0] next_pos;
  logic [7:0] next_neg;
  logic next_half;
  logic next_start;
  logic trig_hit;

  ahb_reg_slave u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .acc(acc)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register file
  always_comb begin
    case (acc.rd_index)
      input_control_index: acc.rd_data = input_control;
      data_high_index: acc.rd_data = data_high;
      default: acc.rd_data = 8'h00;
    endcase
  end

  always_comb begin
    next_input_control = input_control;
    if (acc.wr_en && acc.wr_index == input_control_index) begin
      next_input_control = acc.wr_data;
    end
    next_data_high = result_load ? result_high : data_high;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // input routing, reference and trigger
  function automatic logic [7:0] one_hot8(input logic [2:0] idx);
    one_hot8 = 8'h01 << idx;
  endfunction

  always_comb begin
    next_pos = 8'h00;
    next_neg = 8'h00;
    next_half = 1'b0;
    if (input_control[connect_bit]) begin
      if (!input_control[differential_enable_bit]) begin
        next_pos = one_hot8(input_control[chan_hi:chan_lo]); // [R3] [R6]
        next_half = 1'b1; // [R3]
      end else if (!input_control[chan_hi]) begin
        // pairs: code k uses pins 2k and 2k+1, codes 4..7 reserved
        next_pos = one_hot8({input_control[chan_hi-1:chan_lo], 1'b0}); // [R6]
        next_neg = one_hot8({input_control[chan_hi-1:chan_lo], 1'b1}); // [R6]
      end
    end
    // connect low leaves all enables at zero [R2]
    case (input_control[trig_hi:trig_lo])
      trig_software: trig_hit = go_bit; // [R8]
      trig_timer0: trig_hit = timer0_overflow; // [R7] [R8]
      trig_timer1: trig_hit = timer1_overflow; // [R7] [R8]
      trig_timer2: trig_hit = timer2_overflow; // [R7] [R8]
      default: trig_hit = 1'b0;
    endcase
    next_start = trig_hit;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_control <= input_control_reset; // [R1]
      data_high <= data_high_reset;
      positive_input_enable <= 8'h00;
      negative_input_enable <= 8'h00;
      half_supply_negative <= 1'b0;
      internal_reference_select <= 1'b0;
      differential_enable <= 1'b0;
      conversion_start <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      input_control <= next_input_control;
      data_high <= next_data_high;
      positive_input_enable <= next_pos;
      negative_input_enable <= next_neg;
      half_supply_negative <= next_half;
      internal_reference_select <= input_control[internal_reference_select_bit]; // [R5]
      differential_enable <= input_control[differential_enable_bit]; // [R6]
      conversion_start <= next_start;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: tb/adc_ctrl_asserts.sv
// checker for the converter input control ports
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go_bit,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  input wire logic [7:0] positive_input_enable,
  input wire logic [7:0] negative_input_enable,
  input wire logic half_supply_negative,
  input wire logic differential_enable,
  input wire logic conversion_start
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  rst_clear_a: assert property ($rose(hresetn) |-> positive_input_enable == 8'h00
    && !conversion_start) else $error("reset");
  off_gate_a: assert property (positive_input_enable == 8'h00 |->
    negative_input_enable == 8'h00 && !half_supply_negative) else $error("off");
  one_pin_a: assert property ($onehot0(positive_input_enable)) else $error("pins");
  half_ref_a: assert property (half_supply_negative |-> !differential_enable) else $error("half");
  se_neg_a: assert property (!differential_enable |-> negative_input_enable == 8'h00)
    else $error("single");
  differential_enable_pair_a: assert property (differential_enable && |positive_input_enable |->
    negative_input_enable == positive_input_enable << 1) else $error("pair");
  start_cause_a: assert property (conversion_start |-> $past(go_bit ||
    timer0_overflow || timer1_overflow || timer2_overflow)) else $error("start");
endmodule
////////////////////////////////////////
bind adc_input_control_regs adc_ctrl_chk chk (.*);
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the converter input control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import adc_ctrl_pkg::*;
  logic hclk = 0, hresetn = 0, hwrite = 0, result_load = 0, hreadyout, hresp;
  logic go_bit = 0, timer0_overflow = 0, timer1_overflow = 0, timer2_overflow = 0;
  logic half_supply_negative, internal_reference_select, differential_enable;
  logic conversion_start;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [7:0] result_high = 0, positive_input_enable, negative_input_enable;
  int errors = 0, checks_done = 0;
  // control byte, then positive, negative and {half, internal_reference_select, differential_enable}; connect low in every write that moves the channel
  logic [31:0] rows [13] = '{32'h0, 32'h80010004, 32'h0, 32'h07000000, 32'h87800004,
    32'h47000002, 32'h4b000003, 32'hcb408003, 32'h4a000003, 32'hca102003,
    32'h4c000003, 32'hcc000003, 32'h0c000001};
  wire [31:0] outs = {8'h0, positive_input_enable, negative_input_enable, 5'h0,
    half_supply_negative, internal_reference_select, differential_enable};
  always #20 hclk = ~hclk;
  adc_input_control_regs uut (.*, .hsel(1'b1), .hsize(hsize_word), .hready(hreadyout));
  ////////////////////////////////////////
  task cmp(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] i, d);
    @(posedge hclk);
    htrans <= htrans_nonseq;
    hwrite <= w;
    haddr <= {22'h0, i, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task chk(input logic [7:0] i, e);
    bus(1'b0, i, 8'h00);
    cmp(r, {24'h0, e});
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    #1 cmp(outs, 32'h0);
    cmp({30'h0, hreadyout, hresp}, 32'h2);
    chk(8'hda, 8'h00);
    foreach (rows[k]) begin
      bus(1'b1, 8'hda, rows[k][31:24]);
      repeat (2) @(posedge hclk);
      #1 cmp(outs, {8'h0, rows[k][23:0]});
      chk(8'hda, rows[k][31:24]);
    end
    $display("routing done");
    result_high <= 8'ha5;
    result_load <= 1'b1;
    @(posedge hclk);
    result_load <= 1'b0;
    bus(1'b1, 8'hdd, 8'hff);
    chk(8'hdd, 8'ha5);
    chk(8'h00, 8'h00);
    $display("data high done");
    for (int t = 0; t < 4; t++) begin
      bus(1'b1, 8'hda, {2'h0, 2'(t), 4'h0});
      repeat (2) @(posedge hclk);
      for (int s = 0; s < 4; s++) begin
        {timer2_overflow, timer1_overflow, timer0_overflow, go_bit} <= 4'(1 << s);
        @(posedge hclk);
        {timer2_overflow, timer1_overflow, timer0_overflow, go_bit} <= 4'h0;
        #1 cmp({31'h0, conversion_start}, {31'h0, s == t});
        @(posedge hclk);
      end
    end
    $display("trigger done");
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    #1 cmp(outs, 32'h0);
    cmp({30'h0, hreadyout, hresp}, 32'h2);
    chk(8'hda, 8'h00);
    $display("reset done");
    report_and_stop;
  end
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
